/* File: src/plc_output_assembly_tracking.sv */
`timescale 1ns/1ps
module plc_output_assembly_tracking import plc_out_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input word_wr_t wr_in,
	input wire logic rd_en_in,
	input wire logic [ADDR_W-1:0] rd_addr_in,
	input wire logic [NUM_ZONES-1:0] zone_discharge_in,
	input wire logic [NUM_ZONES-1:0] carton_arrive_in,
	output logic [WORD_W-1:0] rd_data_out,
	output logic rd_valid_out,
	output logic rd_hit_out,
	output logic wr_hit_out,
	output logic [NUM_ZONES-1:0] accum_enable_out,
	output logic [NUM_ZONES-1:0] release_out,
	output logic [NUM_ZONES-1:0] zone_armed_out,
	output track_pair_t [NUM_ZONES-1:0] live_track_out
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic [5:0] wr_slot;
	logic [5:0] rd_slot;
	logic wr_hit;
	logic rd_hit;
	logic rd_hit_r;
	logic rd_valid_r;

	assign wr_slot = slot_of(wr_in.addr);
	assign rd_slot = slot_of(rd_addr_in);
	assign wr_hit = wr_slot[5];
	assign rd_hit = rd_slot[5];
	assign wr_hit_out = wr_in.en && wr_hit;

	// every mapped word lands in the store so it can be read back
	word_store #(
		.DEPTH(NUM_SLOTS),
		.AW(SLOT_W),
		.DW(WORD_W)
	) u_store (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.wr_en_in(wr_in.en && wr_hit),
		.wr_slot_in(wr_slot[SLOT_W-1:0]),
		.wr_data_in(wr_in.data),
		.rd_en_in(rd_en_in),
		.rd_hit_in(rd_hit),
		.rd_slot_in(rd_slot[SLOT_W-1:0]),
		.rd_data_out(rd_data_out)
	);

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_valid_r <= 1'b0;
			rd_hit_r <= 1'b0;
		end else begin
			rd_valid_r <= rd_en_in;
			rd_hit_r <= rd_en_in && rd_hit;
		end
	end

	assign rd_valid_out = rd_valid_r;
	assign rd_hit_out = rd_hit_r;

	// ------------------------------------------------------------------
	// per-zone words that drive logic
	// ------------------------------------------------------------------
	localparam logic [8:0] STAGE_W1_ADDR [NUM_ZONES] = '{ADDR_UP_STAGE_W1, ADDR_DN_STAGE_W1};
	localparam logic [8:0] STAGE_W2_ADDR [NUM_ZONES] = '{ADDR_UP_STAGE_W2, ADDR_DN_STAGE_W2};
	localparam logic [8:0] ACCUM_ADDR [NUM_ZONES] = '{ADDR_UP_ACCUM_CTRL, ADDR_DN_ACCUM_CTRL};
	localparam logic [8:0] RELEASE_ADDR [NUM_ZONES] = '{ADDR_UP_RELEASE, ADDR_DN_RELEASE};

	track_pair_t [NUM_ZONES-1:0] stage_r;
	logic [NUM_ZONES-1:0][WORD_W-1:0] accum_r;
	logic [NUM_ZONES-1:0][WORD_W-1:0] release_word_r;
	logic [NUM_ZONES-1:0] plc_release;
	logic [NUM_ZONES-1:0] zone_release;
	logic [NUM_ZONES-1:0] w2_seen_r;

	genvar z;
	generate
		for (z = 0; z < NUM_ZONES; z++) begin : g_zone
			// staging words are holding registers only: a write here never
			// touches live tracking, so the host's cyclic refresh is harmless
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					stage_r[z] <= '0;
				end else if (wr_in.en) begin
					if (wr_in.addr == STAGE_W1_ADDR[z]) begin
						stage_r[z].w1 <= wr_in.data;
					end
					if (wr_in.addr == STAGE_W2_ADDR[z]) begin
						stage_r[z].w2 <= wr_in.data;
					end
				end
			end

			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					accum_r[z] <= WORD_RESET;
				end else if (wr_in.en && wr_in.addr == ACCUM_ADDR[z]) begin
					accum_r[z] <= wr_in.data;
				end
			end

			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					release_word_r[z] <= WORD_RESET;
				end else if (wr_in.en && wr_in.addr == RELEASE_ADDR[z]) begin
					release_word_r[z] <= wr_in.data;
				end
			end

			// store words are not reset, so readback of staging is only
			// meaningful once the host has written the word
			always_ff @(posedge clk_in or posedge sys_rst_in) begin
				if (sys_rst_in) begin
					w2_seen_r[z] <= 1'b0;
				end else if (wr_in.en && wr_in.addr == STAGE_W2_ADDR[z]) begin
					w2_seen_r[z] <= 1'b1;
				end
			end

			// rewriting the same value is only the cyclic refresh, not a release
			assign plc_release[z] = accum_r[z][ACCUM_ENABLE_BIT] && wr_in.en
				&& (wr_in.addr == RELEASE_ADDR[z])
				&& (wr_in.data != release_word_r[z]);
			assign zone_release[z] = plc_release[z] || zone_discharge_in[z];
			assign accum_enable_out[z] = accum_r[z][ACCUM_ENABLE_BIT];

			// staging as it stands before this cycle's write is what commits
			zone_tracker u_zone (
				.clk_in(clk_in),
				.sys_rst_in(sys_rst_in),
				.stage_in(stage_r[z]),
				.release_in(zone_release[z]),
				.arrive_in(carton_arrive_in[z]),
				.live_out(live_track_out[z]),
				.armed_out(zone_armed_out[z])
			);

			// ----------------------------------------------------------
			// checks
			// ----------------------------------------------------------
			sequence change_req_s;
				wr_in.en && wr_in.addr == RELEASE_ADDR[z]
					&& wr_in.data != release_word_r[z];
			endsequence

			a_release_change: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				change_req_s and accum_r[z][ACCUM_ENABLE_BIT] |-> release_out[z])
				else $error("release word change did not release");

			a_release_gated: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				!accum_r[z][ACCUM_ENABLE_BIT] && !zone_discharge_in[z]
				|-> !release_out[z])
				else $error("release without accumulate enable");

			a_stage_hold: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				wr_in.en && wr_in.addr == STAGE_W1_ADDR[z]
				|=> stage_r[z].w1 == $past(wr_in.data))
				else $error("staging word 1 not captured");

			a_stage_no_live: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				wr_in.en && wr_in.addr == STAGE_W2_ADDR[z] && !zone_release[z]
				|=> live_track_out[z] == $past(live_track_out[z]))
				else $error("staging write reached live tracking");

			a_same_cycle: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				zone_release[z] && !(stage_r[z].w1 == TRACK_KEEP && stage_r[z].w2 == TRACK_KEEP)
				&& !(stage_r[z].w1 == TRACK_CLEAR && stage_r[z].w2 == TRACK_CLEAR)
				|=> live_track_out[z].w1 == $past(stage_r[z].w1)
				&& live_track_out[z].w2 == $past(stage_r[z].w2))
				else $error("live words not updated together");

			sequence stage_w2_wr_s;
				wr_in.en && wr_in.addr == STAGE_W2_ADDR[z];
			endsequence

			a_stage_hold_w2: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				stage_w2_wr_s |=> stage_r[z].w2 == $past(wr_in.data))
				else $error("staging word 2 not captured");

			a_stage_kept: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				!(wr_in.en && (wr_in.addr == STAGE_W1_ADDR[z]
				|| wr_in.addr == STAGE_W2_ADDR[z]))
				|=> stage_r[z] == $past(stage_r[z]))
				else $error("staging changed without a write");

			a_stage_readback: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				rd_en_in && rd_addr_in == STAGE_W2_ADDR[z] && w2_seen_r[z]
				|=> rd_data_out == $past(stage_r[z].w2))
				else $error("staging word 2 readback wrong");

			a_accum_follow: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				wr_in.en && wr_in.addr == ACCUM_ADDR[z]
				|=> accum_enable_out[z] == $past(wr_in.data[ACCUM_ENABLE_BIT]))
				else $error("accumulate enable not taken from write");

			a_release_stored: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				wr_in.en && wr_in.addr == RELEASE_ADDR[z]
				|=> release_word_r[z] == $past(wr_in.data))
				else $error("release word not stored");

			a_refresh_quiet: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				wr_in.en && wr_in.addr == RELEASE_ADDR[z] && wr_in.data == release_word_r[z]
				&& !zone_discharge_in[z] |-> !release_out[z])
				else $error("same release word released");

			a_discharge_rel: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				zone_discharge_in[z] |-> release_out[z])
				else $error("discharge did not release");

			a_arm_out: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				release_out[z] |=> zone_armed_out[z])
				else $error("zone output not armed after release");

			a_arrive_clear: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				zone_armed_out[z] && carton_arrive_in[z] && !release_out[z]
				|=> !zone_armed_out[z])
				else $error("arrival left zone armed");

			a_keep_zone: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				release_out[z] && stage_r[z] == {TRACK_KEEP, TRACK_KEEP}
				|=> live_track_out[z] == $past(live_track_out[z]))
				else $error("keep release changed live words");

			a_clear_zone: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				release_out[z] && stage_r[z] == {TRACK_CLEAR, TRACK_CLEAR}
				|=> live_track_out[z] == {WORD_RESET, WORD_RESET})
				else $error("clear release left live words");

			a_literal_zone: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				release_out[z] && stage_r[z].w1 == TRACK_CLEAR
				&& stage_r[z].w2 != TRACK_CLEAR
				|=> live_track_out[z].w1 == TRACK_CLEAR)
				else $error("single all-ones word not literal");

			a_no_release_live: assert property (@(posedge clk_in)
				disable iff (sys_rst_in)
				!release_out[z] |=> $stable(live_track_out[z]))
				else $error("live words moved without release");
		end
	endgenerate

	assign release_out = zone_release;

	// ------------------------------------------------------------------
	// bus checks
	// ------------------------------------------------------------------
	a_map_stage: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rd_en_in && (rd_addr_in == ADDR_UP_STAGE_W1 || rd_addr_in == ADDR_DN_STAGE_W2)
		|=> rd_valid_out && rd_hit_out)
		else $error("staging address not mapped");

	a_unmapped_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rd_en_in && !rd_hit |=> rd_valid_out && !rd_hit_out && rd_data_out == 16'h0000)
		else $error("unmapped read not zero");

	a_rd_answer: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rd_en_in |=> rd_valid_out)
		else $error("read not answered next cycle");

	a_rd_quiet: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!rd_en_in |=> !rd_valid_out && !rd_hit_out)
		else $error("read answer without request");

	a_rd_stands: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!rd_en_in |=> $stable(rd_data_out))
		else $error("read data moved without request");

	a_wr_hit_map: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		wr_in.en && (wr_in.addr == ADDR_UP_STAGE_W1 || wr_in.addr == ADDR_DN_STAGE_W2)
		|-> wr_hit_out)
		else $error("staging write not mapped");

	a_map_release: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rd_en_in && (rd_addr_in == ADDR_UP_RELEASE || rd_addr_in == ADDR_DN_RELEASE)
		|=> rd_hit_out)
		else $error("release word not mapped");

endmodule : plc_output_assembly_tracking

/* File: src/plc_out_pkg.sv */
package plc_out_pkg;

	// ------------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 9;
	localparam int SLOT_W = 5;
	localparam int NUM_SLOTS = 25;
	localparam int NUM_ZONES = 2;
	localparam int ZONE_UP = 0;
	localparam int ZONE_DN = 1;

	// ------------------------------------------------------------------
	// module addresses of the output words
	// ------------------------------------------------------------------
	localparam logic [8:0] ADDR_STOP_COMMAND = 9'h014;
	localparam logic [8:0] ADDR_MOTOR_FAULT_CLEAR = 9'h016;
	localparam logic [8:0] ADDR_LEFT_ROLLER_SPEED = 9'h028;
	localparam logic [8:0] ADDR_PORT_OUTPUT_DRIVE = 9'h03F;
	localparam logic [8:0] ADDR_RIGHT_ROLLER_SPEED = 9'h040;
	localparam logic [8:0] ADDR_UP_ACCUM_CTRL = 9'h068;
	localparam logic [8:0] ADDR_UP_RELEASE = 9'h069;
	localparam logic [8:0] ADDR_UP_JAM_CLEAR = 9'h06D;
	localparam logic [8:0] ADDR_UP_STAGE_W1 = 9'h084;
	localparam logic [8:0] ADDR_UP_STAGE_W2 = 9'h085;
	localparam logic [8:0] ADDR_INDUCT_SIDE_STATUS = 9'h086;
	localparam logic [8:0] ADDR_INDUCT_FWD_W1 = 9'h08B;
	localparam logic [8:0] ADDR_INDUCT_FWD_W2 = 9'h08C;
	localparam logic [8:0] ADDR_DN_ACCUM_CTRL = 9'h0B8;
	localparam logic [8:0] ADDR_DN_RELEASE = 9'h0B9;
	localparam logic [8:0] ADDR_DN_JAM_CLEAR = 9'h0BD;
	localparam logic [8:0] ADDR_DN_STAGE_W1 = 9'h0D4;
	localparam logic [8:0] ADDR_DN_STAGE_W2 = 9'h0D5;
	localparam logic [8:0] ADDR_DISCHARGE_SIDE_STATUS = 9'h0E8;
	localparam logic [8:0] ADDR_INDUCT_REV_W1 = 9'h0ED;
	localparam logic [8:0] ADDR_INDUCT_REV_W2 = 9'h0EE;
	localparam logic [8:0] ADDR_UP_DIR_ACCUM_MODE = 9'h16D;
	localparam logic [8:0] ADDR_DN_DIR_ACCUM_MODE = 9'h177;
	localparam logic [8:0] ADDR_MERGE_INTERFACE = 9'h183;

	// ------------------------------------------------------------------
	// fields and reserved values
	// ------------------------------------------------------------------
	localparam int ACCUM_ENABLE_BIT = 0;
	localparam logic [15:0] TRACK_KEEP = 16'h0000;
	localparam logic [15:0] TRACK_CLEAR = 16'hFFFF;
	localparam logic [15:0] WORD_RESET = 16'h0000;

	typedef struct packed {
		logic [15:0] w1;
		logic [15:0] w2;
	} track_pair_t;

	typedef struct packed {
		logic en;
		logic [8:0] addr;
		logic [15:0] data;
	} word_wr_t;

	typedef enum logic {
		ZONE_HOLDING = 1'b0,
		ZONE_ARMED = 1'b1
	} zone_state_t;

	// slot number is the position in the cyclic output image; msb marks a hit
	function automatic logic [5:0] slot_of(input logic [8:0] addr);
		logic [5:0] s;
		s = 6'h00;
		unique case (addr)
			ADDR_UP_STAGE_W1: s = 6'h20;
			ADDR_UP_STAGE_W2: s = 6'h21;
			ADDR_DN_STAGE_W1: s = 6'h22;
			ADDR_DN_STAGE_W2: s = 6'h23;
			ADDR_UP_ACCUM_CTRL: s = 6'h24;
			ADDR_DN_ACCUM_CTRL: s = 6'h25;
			ADDR_LEFT_ROLLER_SPEED: s = 6'h26;
			ADDR_RIGHT_ROLLER_SPEED: s = 6'h27;
			ADDR_UP_RELEASE: s = 6'h28;
			ADDR_DN_RELEASE: s = 6'h29;
			ADDR_INDUCT_SIDE_STATUS: s = 6'h2A;
			ADDR_DISCHARGE_SIDE_STATUS: s = 6'h2B;
			ADDR_INDUCT_FWD_W1: s = 6'h2C;
			ADDR_INDUCT_FWD_W2: s = 6'h2D;
			ADDR_INDUCT_REV_W1: s = 6'h2E;
			ADDR_INDUCT_REV_W2: s = 6'h2F;
			ADDR_MOTOR_FAULT_CLEAR: s = 6'h30;
			ADDR_PORT_OUTPUT_DRIVE: s = 6'h31;
			ADDR_STOP_COMMAND: s = 6'h33;
			ADDR_UP_JAM_CLEAR: s = 6'h34;
			ADDR_DN_JAM_CLEAR: s = 6'h35;
			ADDR_UP_DIR_ACCUM_MODE: s = 6'h36;
			ADDR_DN_DIR_ACCUM_MODE: s = 6'h37;
			ADDR_MERGE_INTERFACE: s = 6'h38;
			default: s = 6'h00;
		endcase
		return s;
	endfunction : slot_of

endpackage : plc_out_pkg

/* File: src/word_store.sv */
`timescale 1ns/1ps
module word_store import plc_out_pkg::*; #(
	parameter int DEPTH = NUM_SLOTS,
	parameter int AW = SLOT_W,
	parameter int DW = WORD_W
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic wr_en_in,
	input wire logic [AW-1:0] wr_slot_in,
	input wire logic [DW-1:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic rd_hit_in,
	input wire logic [AW-1:0] rd_slot_in,
	output logic [DW-1:0] rd_data_out
);

	// array has no reset: it is a memory, the host rewrites it every cycle of its image
	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk_in) begin
		if (wr_en_in) begin
			mem[wr_slot_in] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rd_data_out <= WORD_RESET;
		end else if (rd_en_in) begin
			rd_data_out <= rd_hit_in ? mem[rd_slot_in] : WORD_RESET;
		end
	end

endmodule : word_store

/* File: src/zone_tracker.sv */
`timescale 1ns/1ps
module zone_tracker import plc_out_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input track_pair_t stage_in,
	input wire logic release_in,
	input wire logic arrive_in,
	output track_pair_t live_out,
	output logic armed_out
);

	zone_state_t state_r;
	logic both_clear;
	logic both_keep;

	assign both_clear = (stage_in.w1 == TRACK_CLEAR) && (stage_in.w2 == TRACK_CLEAR);
	assign both_keep = (stage_in.w1 == TRACK_KEEP) && (stage_in.w2 == TRACK_KEEP);

	// ------------------------------------------------------------------
	// live tracking commit
	// ------------------------------------------------------------------
	// both words decided from the same cycle's staging, written together
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			live_out <= '0;
		end else if (release_in) begin
			if (both_clear) begin
				live_out <= '0;
			end else if (!both_keep) begin
				live_out <= stage_in;
			end
		end
	end

	// ------------------------------------------------------------------
	// accumulate-next-arrival arming
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_r <= ZONE_HOLDING;
		end else begin
			unique case (state_r)
				ZONE_HOLDING: begin
					if (release_in) begin
						state_r <= ZONE_ARMED;
					end
				end
				ZONE_ARMED: begin
					if (arrive_in && !release_in) begin
						state_r <= ZONE_HOLDING;
					end
				end
			endcase
		end
	end

	assign armed_out = (state_r == ZONE_ARMED);

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence rel_keep_s;
		release_in && both_keep;
	endsequence

	sequence rel_clear_s;
		release_in && both_clear;
	endsequence

	a_keep_live: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rel_keep_s |=> live_out == $past(live_out))
		else $error("live tracking changed on keep release");

	a_clear_live: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		rel_clear_s |=> live_out.w1 == 16'h0000 && live_out.w2 == 16'h0000)
		else $error("live tracking not cleared");

	a_literal_ffff: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		release_in && !both_clear && !both_keep
		|=> live_out == $past(stage_in))
		else $error("staging not taken literally");

	a_no_commit: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!release_in |=> $stable(live_out))
		else $error("live tracking changed without release");

	a_arm_after: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		release_in |=> armed_out)
		else $error("zone not armed after release");

endmodule : zone_tracker

/* File: verification/plc_image_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// controller model: rewrites its whole output image, one word a cycle
// ----------------------------------------------------------------
module plc_image_model import plc_out_pkg::*; (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [15:0] img_in [9],
	output word_wr_t wr_out
);
	// last slot is unmapped so refused writes are exercised every round
	localparam logic [8:0] MAP [9] = '{ADDR_UP_STAGE_W1, ADDR_UP_STAGE_W2, ADDR_DN_STAGE_W1,
		ADDR_DN_STAGE_W2, ADDR_UP_ACCUM_CTRL, ADDR_DN_ACCUM_CTRL, ADDR_UP_RELEASE,
		ADDR_DN_RELEASE, 9'h001};
	logic [3:0] idx_r;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			idx_r <= 4'h0;
			wr_out <= '0;
		end else begin
			wr_out.en <= 1'b1;
			wr_out.addr <= MAP[idx_r];
			wr_out.data <= img_in[idx_r];
			idx_r <= (idx_r == 4'h8) ? 4'h0 : idx_r + 4'h1;
		end
	end
endmodule : plc_image_model

/* File: verification/plc_output_assembly_tracking_test.sv */
`timescale 1ns/1ps
module plc_output_assembly_tracking_test import plc_out_pkg::*; ;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic [15:0] img [9] = '{default: 16'h0000};
	word_wr_t wr;
	logic rd_en_in = 1'b0;
	logic [8:0] rd_addr_in = 9'h000;
	logic [1:0] zone_discharge_in = 2'h0;
	logic [1:0] carton_arrive_in = 2'h0;
	logic [15:0] rd_data_out;
	logic rd_valid_out, rd_hit_out, wr_hit_out;
	logic [1:0] accum_enable_out, release_out, zone_armed_out;
	track_pair_t [1:0] live_track_out;
	int fails = 0;
	int compares = 0;
	int cyc = 0;
	int rel_cnt [2] = '{0, 0};
	logic [31:0] seed = 32'h19DD;

	always #2 clk_in = ~clk_in;

	plc_image_model partner (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .img_in(img),
		.wr_out(wr));
	plc_output_assembly_tracking dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(wr),
		.rd_en_in(rd_en_in), .rd_addr_in(rd_addr_in), .zone_discharge_in(zone_discharge_in),
		.carton_arrive_in(carton_arrive_in), .rd_data_out(rd_data_out),
		.rd_valid_out(rd_valid_out), .rd_hit_out(rd_hit_out), .wr_hit_out(wr_hit_out),
		.accum_enable_out(accum_enable_out), .release_out(release_out),
		.zone_armed_out(zone_armed_out), .live_track_out(live_track_out));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic ok, input string msg);
		compares++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask : chk

	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : end_of_test

	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction : rnd

	function automatic track_pair_t exp_of(input track_pair_t old, input track_pair_t s);
		if (s.w1 === TRACK_KEEP && s.w2 === TRACK_KEEP) return old;
		if (s.w1 === TRACK_CLEAR && s.w2 === TRACK_CLEAR) return '0;
		return s;
	endfunction : exp_of

	task automatic rd(input logic [8:0] a, input logic [15:0] d, input logic hit);
		@(posedge clk_in);
		rd_en_in <= 1'b1;
		rd_addr_in <= a;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		#1;
		chk(rd_valid_out === 1'b1 && rd_hit_out === hit && rd_data_out === d, "read word");
	endtask : rd

	// release pulses counted on the edge that takes them
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (release_out[0] === 1'b1) rel_cnt[0] <= rel_cnt[0] + 1;
		if (release_out[1] === 1'b1) rel_cnt[1] <= rel_cnt[1] + 1;
		if (wr.en && wr.addr == 9'h001 && wr_hit_out !== 1'b0) begin
			chk(1'b0, "unmapped write hit");
		end
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		track_pair_t s, ex [2];
		int z, n, k;
		ex = '{default: '0};
		repeat (16) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		img[4] <= 16'h0001;
		img[5] <= 16'h0001;
		repeat (20) @(posedge clk_in);
		#1;
		chk(accum_enable_out === 2'h3 && rel_cnt[0] == 0 && rel_cnt[1] == 0, "accum enable");
		for (int i = 0; i < 24; i++) begin
			z = i % 2;
			s.w1 = rnd();
			s.w2 = rnd();
			case ((i / 2) % 6)
				0: s = '0;
				1: s = {TRACK_CLEAR, TRACK_CLEAR};
				2: s.w1 = TRACK_CLEAR;
				3: s.w2 = TRACK_CLEAR;
				4: s.w1 = TRACK_KEEP;
				default: ;
			endcase
			@(posedge clk_in);
			img[2 * z] <= s.w1;
			img[2 * z + 1] <= s.w2;
			repeat (20) @(posedge clk_in);
			#1;
			chk(live_track_out[z] === ex[z] && rel_cnt[z] == n, "staging alone moved live");
			rd(z ? ADDR_DN_STAGE_W2 : ADDR_UP_STAGE_W2, s.w2, 1'b1);
			n = rel_cnt[z];
			@(posedge clk_in);
			if (i % 4 < 2) begin
				img[6 + z] <= img[6 + z] + 16'h0001;
			end else begin
				zone_discharge_in[z] <= 1'b1;
				@(posedge clk_in);
				zone_discharge_in[z] <= 1'b0;
			end
			k = 0;
			while (rel_cnt[z] == n && k < 30) begin
				@(posedge clk_in);
				#1;
				k++;
			end
			ex[z] = exp_of(ex[z], s);
			chk(rel_cnt[z] == n + 1, "no release");
			chk(live_track_out[z] === ex[z], "live tracking");
			chk(zone_armed_out[z] === 1'b1, "zone not armed");
			n = rel_cnt[1 - z];
			@(posedge clk_in);
			carton_arrive_in[z] <= 1'b1;
			@(posedge clk_in);
			carton_arrive_in[z] <= 1'b0;
			#1;
			chk(zone_armed_out[z] === 1'b0, "arrival kept armed");
			n = rel_cnt[1 - z];
			if (z == 1) n = rel_cnt[0];
		end
		$display("test tracking commit done");
		n = rel_cnt[0];
		@(posedge clk_in);
		img[4] <= 16'h0000;
		img[0] <= 16'h5A5A;
		repeat (20) @(posedge clk_in);
		img[6] <= img[6] + 16'h0001;
		repeat (20) @(posedge clk_in);
		#1;
		chk(rel_cnt[0] == n && live_track_out[0] === ex[0], "release with accumulate off");
		chk(accum_enable_out[0] === 1'b0, "accumulate enable not cleared");
		rd(ADDR_UP_RELEASE, img[6], 1'b1);
		rd(9'h001, 16'h0000, 1'b0);
		$display("test refused release done");
		end_of_test();
	end
endmodule : plc_output_assembly_tracking_test
